// ==== hw/rswc_params.svh ====
// Constants for the reset and sleep/wake-up sequencer.
// Assumes a single 20 MHz system clock; all counts derive from it.
`ifndef RSWC_PARAMS_SVH
`define RSWC_PARAMS_SVH

// System clock rate in kHz
`define RSWC_CLK_KHZ 20000

// Printed times, each in its own unit
`define RSWC_POR_MS 18
`define RSWC_HXT_MS 2
`define RSWC_LXT_MS 500
`define RSWC_WAKE_US 150
`define RSWC_RC_CLKS 34
`define RSWC_HXT_CLKS 32

// Derived cycle counts (least times round up)
`define RSWC_POR_CYC (`RSWC_POR_MS * `RSWC_CLK_KHZ)
`define RSWC_HXT_CYC (`RSWC_HXT_MS * `RSWC_CLK_KHZ + `RSWC_HXT_CLKS)
`define RSWC_LXT_CYC (`RSWC_LXT_MS * `RSWC_CLK_KHZ)
`define RSWC_WAKE_CYC ((`RSWC_WAKE_US * `RSWC_CLK_KHZ + 999) / 1000)

// Widths
`define RSWC_CNT_W 24
`define RSWC_PC_W 10

// Interrupt vector addresses per wake source
`define RSWC_VEC_EXT 10'h003
`define RSWC_VEC_PORT6 10'h006
`define RSWC_VEC_CMP 10'h015
`define RSWC_VEC_OTHER 10'h030

// Status flag values at power-on
`define RSWC_T_POR 1'b1
`define RSWC_P_POR 1'b1

`endif

// ==== hw/rswc_pkg.sv ====
// Types shared by the reset and sleep/wake-up sequencer.
// Assumes rswc_params.svh is on the include path.
`include "rswc_params.svh"

package rswc_pkg;

	// Oscillator mode chosen by configuration
	typedef enum logic [1:0] {OSC_RC, OSC_HXT, OSC_LXT} rswc_osc_t;

	// Wake source that ended a sleep
	typedef enum logic [2:0] {
		SRC_NONE, SRC_EXT, SRC_PORT6, SRC_CMP,
		SRC_ADC, SRC_SPI, SRC_PORT57, SRC_TIMER
	} rswc_src_t;

	// Wake enable bits
	typedef struct packed {
		logic extPinWakeEn;
		logic port6ChangeWakeEn;
		logic comparator1WakeEn;
		logic comparator2WakeEn;
		logic adcDoneWakeEn;
		logic spiRxWakeEn;
		logic port5WakeEn;
		logic port7WakeEn;
	} rswc_wake_en_t;

	// Wake events, one-cycle pulses from peripherals
	typedef struct packed {
		logic extPin;
		logic port6;
		logic cmp1;
		logic cmp2;
		logic adcDone;
		logic spiRx;
		logic port5;
		logic port7;
		logic tickOvf;
		logic tmr1;
		logic tmr2;
		logic tmr3;
		logic pwmMatch;
	} rswc_wake_ev_t;

	// Core control
	typedef struct packed {
		logic coreHold;
		logic pcClear;
		logic portsInput;
		logic wdtClear;
		logic powerDown;
		logic mainOscRun;
		logic subOscRun;
	} rswc_ctl_t;

	// Resume after wake-up
	typedef struct packed {
		logic resumePulse;
		logic vectorJump;
		logic [`RSWC_PC_W-1:0] vectorAddr;
	} rswc_resume_t;

	// Status flags
	typedef struct packed {
		logic timeoutFlag;
		logic powerDownFlag;
	} rswc_flags_t;

endpackage

// ==== hw/rswc_top.sv ====
// Reset and sleep/wake-up sequencer for an 8-bit core.
// Assumes one 20 MHz clock; the reset pin is asynchronous,
// all other inputs come from logic on the same clock.
//
// Operation
// - Reset on power-on, reset pin low, or enabled watchdog time-out.
// - After power-on, hold reset for one start-up period, about 18 ms.
// - Pin or watchdog reset: 34 clocks RC, 2 ms+32 clocks HXT, 500 ms LXT.
// - Reset keeps the oscillator running and clears the program counter.
// - Reset turns every port pin to input, drivers high impedance.
// - Reset clears the watchdog counter and its prescaler.
// - Sleep instruction powers down; watchdog cleared on entry, keeps counting.
// - Each non-reset wake source except tick, timer and PWM wakes only with its own enable bit.
// - Pin or watchdog wake resets; T and P flags show which.
// - Other wakes continue; interrupts off means next instruction.
// - Interrupts on before sleep means branch to the source vector.
// - Port 5 or port 7 wake never raises an interrupt.
// - Wake-up delay is 150 us, or 500 ms in low-crystal mode.
// - Watchdog on at sleep: only pin or watchdog can wake.
// - Tick, timer and PWM events wake from idle only, not sleep.
// - UART events never wake from sleep or idle.
// - Conversion in use keeps both clocks in green, or at sleep or idle with its wake enable set.
// - SPI wakes only as slave with its wake enable set.
`include "rswc_params.svh"

module rswc_top #(
	parameter int unsigned PorHoldCyc = `RSWC_POR_CYC,
	parameter int unsigned HxtCyc     = `RSWC_HXT_CYC,
	parameter int unsigned LxtCyc     = `RSWC_LXT_CYC
) (
	input  wire logic                   clock,
	input  wire logic                   rst,
	input  wire logic                   extResetPinN,
	input  wire logic                   wdtEnable,
	input  wire logic                   wdtTimeout,
	input  wire rswc_pkg::rswc_osc_t    oscMode,
	input  wire logic                   sleepInstruction,
	input  wire logic                   idleSelect,
	input  wire logic                   greenMode,
	input  wire logic                   globalIntEnableInstr,
	input  wire logic                   globalIntDisableInstr,
	input  wire logic                   spiIsSlave,
	input  wire logic                   adcActive,
	input  wire rswc_pkg::rswc_wake_en_t wakeEn,
	input  wire rswc_pkg::rswc_wake_ev_t wakeEv,
	output rswc_pkg::rswc_ctl_t         ctl,
	output rswc_pkg::rswc_resume_t      resume,
	output rswc_pkg::rswc_flags_t       flags
);
	import rswc_pkg::*;

	localparam int CW = `RSWC_CNT_W;
	localparam int PW = `RSWC_PC_W;

	// Refuse counts the delay counter cannot hold
	if (PorHoldCyc < 1 || PorHoldCyc >= (1 << CW))
		$error("PorHoldCyc out of range");
	if (HxtCyc < 1 || HxtCyc >= (1 << CW))
		$error("HxtCyc out of range");
	if (LxtCyc < 1 || LxtCyc >= (1 << CW))
		$error("LxtCyc out of range");

	typedef enum logic [1:0] {
		ST_HOLD, ST_RUN, ST_SLEEP, ST_WAKE
	} rswc_state_t;

	// Reset length after a pin or watchdog event
	function automatic logic [CW-1:0] rstLen(input rswc_osc_t m);
		unique case (m)
			OSC_RC:  rstLen = CW'(`RSWC_RC_CLKS);
			OSC_HXT: rstLen = CW'(HxtCyc);
			OSC_LXT: rstLen = CW'(LxtCyc);
			default: rstLen = CW'(LxtCyc);
		endcase
	endfunction

	// Wake-up delay; low crystal needs the long start-up
	function automatic logic [CW-1:0] wakeLen(input rswc_osc_t m);
		wakeLen = (m == OSC_LXT) ? CW'(LxtCyc)
			: CW'(`RSWC_WAKE_CYC);
	endfunction

	// Registers
	rswc_state_t     state_r;
	rswc_state_t     state_nxt;
	logic [CW-1:0]   cnt_r;
	logic [CW-1:0]   cnt_nxt;
	logic            pinMeta_r;
	logic            pinSync_r;
	logic            intEn_r;
	logic            intAtSleep_r;
	logic            wdtAtSleep_r;
	logic            idle_r;
	rswc_src_t       src_r;
	rswc_src_t       src_nxt;
	rswc_ctl_t       ctl_r;
	rswc_ctl_t       ctl_nxt;
	rswc_resume_t    res_r;
	rswc_resume_t    res_nxt;
	rswc_flags_t     flg_r;
	rswc_flags_t     flg_nxt;

	// Reset pin passes two flops; only the second is read
	always_ff @(posedge clock) begin
		if (rst) begin
			pinMeta_r <= 1'b1;
			pinSync_r <= 1'b1;
		end else begin
			pinMeta_r <= extResetPinN;
			pinSync_r <= pinMeta_r;
		end
	end

	// Reset causes
	wire pinLow  = ~pinSync_r;
	wire wdtHit  = wdtTimeout & wdtEnable;
	wire rstReq  = pinLow | wdtHit;

	// State decode
	wire inRun   = (state_r == ST_RUN);
	wire inSleep = (state_r == ST_SLEEP);
	wire inWake  = (state_r == ST_WAKE);
	wire inHold  = (state_r == ST_HOLD);
	wire cntDone = (cnt_r == CW'(1));
	wire goSleep = inRun & sleepInstruction;

	// Non-reset wake sources, each gated by its own enable
	wire wExt  = wakeEv.extPin & wakeEn.extPinWakeEn;
	wire wP6   = wakeEv.port6 & wakeEn.port6ChangeWakeEn;
	wire wCmp  = (wakeEv.cmp1 & wakeEn.comparator1WakeEn)
		| (wakeEv.cmp2 & wakeEn.comparator2WakeEn);
	wire wAdc  = wakeEv.adcDone & wakeEn.adcDoneWakeEn;
	wire wSpi  = wakeEv.spiRx & wakeEn.spiRxWakeEn
		& spiIsSlave;
	wire wP57  = (wakeEv.port5 & wakeEn.port5WakeEn)
		| (wakeEv.port7 & wakeEn.port7WakeEn);

	// Timer class wakes idle only; UART events have no path here
	wire wTmr  = idle_r & (wakeEv.tickOvf | wakeEv.tmr1
		| wakeEv.tmr2 | wakeEv.tmr3 | wakeEv.pwmMatch);

	// Watchdog on at entry blocks every non-reset wake
	wire nrOk  = ~wdtAtSleep_r;

	// Fixed priority; software is expected to enable only one
	wire rswc_src_t hitSrc =
		!nrOk ? SRC_NONE :
		wExt  ? SRC_EXT :
		wP6   ? SRC_PORT6 :
		wCmp  ? SRC_CMP :
		wAdc  ? SRC_ADC :
		wSpi  ? SRC_SPI :
		wP57  ? SRC_PORT57 :
		wTmr  ? SRC_TIMER : SRC_NONE;
	wire wakeHit = inSleep & (hitSrc != SRC_NONE);

	// Vector for the source that woke the core
	wire logic [PW-1:0] vecAddr =
		(src_r == SRC_EXT)   ? `RSWC_VEC_EXT :
		(src_r == SRC_PORT6) ? `RSWC_VEC_PORT6 :
		(src_r == SRC_CMP)   ? `RSWC_VEC_CMP :
		`RSWC_VEC_OTHER;

	// Port 5/7 wakes resume without an interrupt
	wire srcInts = (src_r != SRC_PORT57);
	wire jumpNow = inWake & cntDone & intAtSleep_r
		& srcInts;

	// Clocks follow the next state so they switch with powerDown, not a cycle late
	wire nxtSleep = (state_nxt == ST_SLEEP);
	wire nxtRun   = (state_nxt == ST_RUN);
	wire idleNxt  = goSleep ? idleSelect : idle_r;
	wire keepClk = adcActive & ((nxtSleep & wakeEn.adcDoneWakeEn)
		| (nxtRun & greenMode));
	wire deepSlp = nxtSleep & ~idleNxt;
	wire idleSlp = nxtSleep & idleNxt;
	wire mainOn  = ~(deepSlp | idleSlp | (nxtRun & greenMode))
		| keepClk | inHold;
	wire subOn   = ~deepSlp | keepClk | inHold;

	// Sequencer: reset requests override every state
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		src_nxt   = src_r;
		flg_nxt   = flg_r;
		if (rstReq) begin
			state_nxt = ST_HOLD;
			cnt_nxt   = rstLen(oscMode);
			if (wdtHit) begin
				flg_nxt.timeoutFlag = 1'b0;
				flg_nxt.powerDownFlag = ~(inSleep | inWake);
			end else if (inSleep | inWake) begin
				flg_nxt.timeoutFlag = 1'b1;
				flg_nxt.powerDownFlag = 1'b0;
			end
		end else begin
			unique case (state_r)
				ST_HOLD: begin
					if (cntDone) begin
						state_nxt = ST_RUN;
					end else begin
						cnt_nxt = cnt_r - CW'(1);
					end
				end
				ST_RUN: begin
					if (goSleep) begin
						state_nxt = ST_SLEEP;
						flg_nxt.timeoutFlag = 1'b1;
						flg_nxt.powerDownFlag = 1'b0;
					end
				end
				ST_SLEEP: begin
					if (wakeHit) begin
						state_nxt = ST_WAKE;
						src_nxt   = hitSrc;
						cnt_nxt   = wakeLen(oscMode);
					end
				end
				ST_WAKE: begin
					if (cntDone) begin
						state_nxt = ST_RUN;
					end else begin
						cnt_nxt = cnt_r - CW'(1);
					end
				end
			endcase
		end
	end

	// Core control outputs for the next cycle
	always_comb begin
		ctl_nxt.coreHold   = (state_nxt == ST_HOLD);
		ctl_nxt.pcClear    = (state_nxt == ST_HOLD);
		ctl_nxt.portsInput = (state_nxt == ST_HOLD);
		ctl_nxt.wdtClear   = (state_nxt == ST_HOLD)
			| goSleep;
		ctl_nxt.powerDown  = (state_nxt == ST_SLEEP)
			| (state_nxt == ST_WAKE);
		ctl_nxt.mainOscRun = mainOn | (state_nxt == ST_HOLD);
		ctl_nxt.subOscRun  = subOn | (state_nxt == ST_HOLD);
		res_nxt.resumePulse = inWake & cntDone & ~rstReq;
		res_nxt.vectorJump  = jumpNow & ~rstReq;
		res_nxt.vectorAddr  = jumpNow ? vecAddr : res_r.vectorAddr;
	end

	// Main state and counter; power-on uses the long start-up
	always_ff @(posedge clock) begin
		if (rst) begin
			state_r <= ST_HOLD;
			cnt_r   <= CW'(PorHoldCyc);
			src_r   <= SRC_NONE;
			flg_r   <= {`RSWC_T_POR, `RSWC_P_POR};
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			src_r   <= src_nxt;
			flg_r   <= flg_nxt;
		end
	end

	// Global interrupt enable follows the enable and disable instructions
	always_ff @(posedge clock) begin
		if (rst | (rstReq & ~inHold)) begin
			intEn_r <= 1'b0;
		end else if (globalIntEnableInstr) begin
			intEn_r <= 1'b1;
		end else if (globalIntDisableInstr) begin
			intEn_r <= 1'b0;
		end
	end

	// Settings frozen at sleep entry decide how the wake ends
	always_ff @(posedge clock) begin
		if (rst) begin
			intAtSleep_r <= 1'b0;
			wdtAtSleep_r <= 1'b0;
			idle_r       <= 1'b0;
		end else if (goSleep) begin
			intAtSleep_r <= intEn_r;
			wdtAtSleep_r <= wdtEnable;
			idle_r       <= idleSelect;
		end
	end

	// Registered outputs; reset holds the core with clocks up
	always_ff @(posedge clock) begin
		if (rst) begin
			ctl_r <= '{coreHold: 1'b1, pcClear: 1'b1,
				portsInput: 1'b1, wdtClear: 1'b1,
				powerDown: 1'b0, mainOscRun: 1'b1,
				subOscRun: 1'b1};
			res_r <= '0;
		end else begin
			ctl_r <= ctl_nxt;
			res_r <= res_nxt;
		end
	end

	// Ports come straight from flops
	assign ctl    = ctl_r;
	assign resume = res_r;
	assign flags  = flg_r;

	// Note: the wake counter shares the hold counter, so a reset
	// during a wake delay simply reloads it with the reset length.
	// Watchdog counting during sleep belongs to the watchdog itself;
	// this block only clears it on entry and never stops it.

endmodule

// ==== testbench/rswc_checker.sv ====
// Port-level timing checks for the reset and sleep/wake-up sequencer.
// Assumes it is bound into rswc_top and shares its clock and reset.
module rswc_checker (
	input wire logic                    clock,
	input wire logic                    rst,
	input wire logic                    extResetPinN,
	input wire logic                    wdtEnable,
	input wire logic                    wdtTimeout,
	input wire logic                    sleepInstruction,
	input wire logic                    adcActive,
	input wire rswc_pkg::rswc_wake_en_t wakeEn,
	input wire rswc_pkg::rswc_ctl_t     ctl,
	input wire rswc_pkg::rswc_resume_t  resume,
	input wire rswc_pkg::rswc_flags_t   flags
);
	import rswc_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// Reset requests must raise the hold within the synchroniser delay
	property p_wdt_rst; wdtEnable && wdtTimeout |-> ##[1:2] ctl.coreHold; endproperty
	a_wdt_rst: assert property (p_wdt_rst) else $error("watchdog time-out left core running");
	property p_pin_rst; !extResetPinN [*3] |-> ##[0:1] ctl.coreHold; endproperty
	a_pin_rst: assert property (p_pin_rst) else $error("reset pin left core running");
	property p_por; $fell(rst) |-> ctl.coreHold && flags.timeoutFlag && flags.powerDownFlag; endproperty
	a_por: assert property (p_por) else $error("power-on state wrong");
	// Everything the core needs cleared stays asserted for the whole hold
	property p_hold; ctl.coreHold |-> ctl.pcClear && ctl.portsInput && ctl.wdtClear && ctl.mainOscRun; endproperty
	a_hold: assert property (p_hold) else $error("hold without core clears");
	// Pin history guards against a reset still in the synchroniser
	property p_sleep;
		sleepInstruction && !ctl.coreHold && !ctl.powerDown && !wdtTimeout && extResetPinN
			&& $past(extResetPinN) && $past(extResetPinN, 2)
			|=> ctl.powerDown && ctl.wdtClear && flags.timeoutFlag && !flags.powerDownFlag;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
	property p_pulse; resume.resumePulse |-> !ctl.powerDown && $past(ctl.powerDown) ##1 !resume.resumePulse; endproperty
	a_pulse: assert property (p_pulse) else $error("resume pulse wrong");
	property p_vec; resume.vectorJump |-> resume.resumePulse; endproperty
	a_vec: assert property (p_vec) else $error("vector jump outside resume");
	property p_adc_osc; ctl.powerDown && adcActive && wakeEn.adcDoneWakeEn |-> ctl.mainOscRun && ctl.subOscRun; endproperty
	a_adc_osc: assert property (p_adc_osc) else $error("clock stopped under conversion");
endmodule

// ==== testbench/rswc_periph_model.sv ====
// Peripherals and reset pin seen from the sequencer's wake inputs.
// Assumes the bench drives fire, srcIdx and pinLow off the rising edge.
module rswc_periph_model (
	input wire logic                   fire,
	input wire logic [3:0]             srcIdx,
	input wire logic                   pinLow,
	output rswc_pkg::rswc_wake_ev_t    wakeEv,
	output logic                       extResetPinN
);
	import rswc_pkg::*;
	// One peripheral at a time; software enables a single source
	assign wakeEv = fire ? rswc_wake_ev_t'(13'h1000 >> srcIdx) : rswc_wake_ev_t'(13'h0000);
	// Pin has a pull-up, so a released pin reads high
	assign extResetPinN = !pinLow;
endmodule

// ==== testbench/test_rswc_top.sv ====
// Self-checking bench for the reset and sleep/wake-up sequencer.
// Assumes shortened hold parameters; the wake delay stays full length.
module test_rswc_top;
	timeunit 1ns;
	timeprecision 1ns;
	import rswc_pkg::*;
	logic          clock, rst, pinLow, fire, wdtEnable, wdtTimeout, sleepInstruction, idleSelect;
	logic          greenMode, intOn, intOff, spiIsSlave, adcActive, extResetPinN, ints;
	logic [3:0]    srcIdx;
	rswc_osc_t     oscMode;
	rswc_wake_en_t wakeEn;
	rswc_wake_ev_t wakeEv;
	rswc_ctl_t     ctl;
	rswc_resume_t  resume;
	rswc_flags_t   flags;
	int            errorCnt, checksDone, cycles, n, s, lens[3];
	logic [31:0]   seed;

	rswc_top #(.PorHoldCyc(20), .HxtCyc(40), .LxtCyc(60)) i_dut (.clock(clock), .rst(rst),
		.extResetPinN(extResetPinN), .wdtEnable(wdtEnable), .wdtTimeout(wdtTimeout), .oscMode(oscMode),
		.sleepInstruction(sleepInstruction), .idleSelect(idleSelect), .greenMode(greenMode),
		.globalIntEnableInstr(intOn), .globalIntDisableInstr(intOff), .spiIsSlave(spiIsSlave),
		.adcActive(adcActive), .wakeEn(wakeEn), .wakeEv(wakeEv), .ctl(ctl), .resume(resume), .flags(flags));
	rswc_periph_model i_periph (.fire(fire), .srcIdx(srcIdx), .pinLow(pinLow), .wakeEv(wakeEv),
		.extResetPinN(extResetPinN));

	function automatic int rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return int'(seed[15:0]);
	endfunction
	// Vector per wake source: external, port 6, comparators, then the rest
	function automatic logic [15:0] expVec(int k);
		return k == 0 ? 16'h0003 : k == 1 ? 16'h0006 : k < 4 ? 16'h0015 : 16'h0030;
	endfunction

	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		checksDone++;
		if (got !== exp) begin
			errorCnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic printVerdict();
		if (errorCnt == 0 && checksDone > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Bounded so a stuck hold cannot hang the run
	task automatic holdLen(output int k);
		k = 0;
		while (ctl.coreHold === 1'b1 && k < 200) begin
			@(negedge clock);
			k++;
		end
	endtask
	task automatic pulse(int k);
		srcIdx = 4'(k);
		fire = 1;
		@(negedge clock);
		fire = 0;
	endtask
	task automatic goSleep(logic wdt, logic ie);
		wdtEnable = wdt;
		intOn = ie;
		intOff = !ie;
		@(negedge clock);
		intOn = 0;
		intOff = 0;
		sleepInstruction = 1;
		@(negedge clock);
		sleepInstruction = 0;
		chk("sleep entry", 16'h000e, {ctl.powerDown, ctl.wdtClear, flags});
	endtask

	// Clock and hang guard
	initial begin
		clock = 0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 60000) begin
			errorCnt++;
			printVerdict();
		end
	end

	// Main sequence
	initial begin
		{rst, pinLow, fire, wdtEnable, wdtTimeout, sleepInstruction, idleSelect, greenMode} = 8'h80;
		{intOn, intOff, spiIsSlave, adcActive} = 4'h0;
		srcIdx = 4'h0;
		oscMode = OSC_RC;
		wakeEn = '0;
		seed = 32'h00000060;
		lens = '{34, 40, 60};
		repeat (10) @(negedge clock);
		rst = 0;
		holdLen(n);
		chk("power-on hold", 16'h0001, 16'(n >= 20 && n <= 22));
		// Watchdog reset length in every oscillator mode
		for (int m = 0; m < 3; m++) begin
			oscMode = rswc_osc_t'(m);
			{wdtEnable, wdtTimeout} = 2'b11;
			@(negedge clock);
			{wdtEnable, wdtTimeout} = 2'b00;
			@(negedge clock);
			chk("wdt flags", 16'h0001, 16'(flags));
			holdLen(n);
			chk("reset length", 16'h0001, 16'(n >= lens[m] - 1 && n <= lens[m] + 3));
		end
		oscMode = OSC_RC;
		// Every source once, then random ones, with refused decoys before each real wake
		for (int i = 0; i < 10; i++) begin
			s = i < 8 ? i : rnd() % 8;
			ints = rnd() & 1;
			adcActive = rnd() & 1;
			spiIsSlave = 1;
			wakeEn = rswc_wake_en_t'(8'h80 >> s);
			goSleep(0, ints);
			chk("sleep clocks", 16'({2{adcActive && s == 4}}), 16'({ctl.mainOscRun, ctl.subOscRun}));
			pulse(8 + rnd() % 5);
			pulse((s + 1) % 8);
			spiIsSlave = 0;
			pulse(5);
			spiIsSlave = 1;
			repeat (3) @(negedge clock);
			chk("still asleep", 16'h0001, 16'(ctl.powerDown));
			pulse(s);
			n = 1;
			while (resume.resumePulse !== 1'b1 && n < 3100) begin
				@(negedge clock);
				n++;
			end
			chk("wake delay", 16'd3001, 16'(n));
			chk("vector jump", 16'(ints && s < 6), 16'(resume.vectorJump));
			if (ints && s < 6) chk("vector", expVec(s), 16'(resume.vectorAddr));
			chk("resumed", 16'h0000, 16'({ctl.powerDown, ctl.coreHold}));
			@(negedge clock);
		end
		// Idle: a timer event wakes with no enable bit needed
		idleSelect = 1;
		wakeEn = '0;
		goSleep(0, 0);
		pulse(9);
		n = 1;
		while (resume.resumePulse !== 1'b1 && n < 3100) begin
			@(negedge clock);
			n++;
		end
		chk("idle timer wake", 16'd3001, 16'(n));
		idleSelect = 0;
		@(negedge clock);
		// Watchdog on at sleep: enabled source refused, time-out resets
		wakeEn = rswc_wake_en_t'(8'h80);
		goSleep(1, 1);
		pulse(0);
		repeat (3) @(negedge clock);
		chk("wdt blocks wake", 16'h0001, 16'(ctl.powerDown));
		wdtTimeout = 1;
		@(negedge clock);
		wdtTimeout = 0;
		@(negedge clock);
		chk("wdt wake", 16'h0004, 16'({ctl.coreHold, flags}));
		holdLen(n);
		// Reset pin wakes from sleep through a reset
		goSleep(0, 0);
		pinLow = 1;
		repeat (3) @(negedge clock);
		pinLow = 0;
		repeat (3) @(negedge clock);
		chk("pin wake", 16'h0006, 16'({ctl.coreHold, flags}));
		holdLen(n);
		printVerdict();
	end
endmodule

bind rswc_top rswc_checker i_chk (.clock(clock), .rst(rst), .extResetPinN(extResetPinN),
	.wdtEnable(wdtEnable), .wdtTimeout(wdtTimeout), .sleepInstruction(sleepInstruction),
	.adcActive(adcActive), .wakeEn(wakeEn), .ctl(ctl), .resume(resume), .flags(flags));
